// ---- design/rsl_defines.svh ----
// constants of the receive silo load sequencer: tick rates, pulse widths, depths
// assumes a single 10 MHz system clock; all rates are derived from it by accumulators
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH

// clock rates in kHz, clock periods in ns
`define RSL_MCLK_KHZ        10000
`define RSL_SCAN_KHZ        2540
`define RSL_SILO_KHZ        5068
`define RSL_MCLK_PERIOD_NS  100
`define RSL_SILO_PERIOD_NS  200

// maintenance pulse width, least time, rounded up to whole cycles
`define RSL_MAINT_PULSE_NS  1000
`define RSL_MAINT_PULSE_CYC ((`RSL_MAINT_PULSE_NS + `RSL_MCLK_PERIOD_NS - 1) / `RSL_MCLK_PERIOD_NS)

// load-request clear pulse, least time, rounded up to whole cycles
`define RSL_CLR_PULSE_NS    30
`define RSL_CLR_PULSE_CYC   ((`RSL_CLR_PULSE_NS + `RSL_MCLK_PERIOD_NS - 1) / `RSL_MCLK_PERIOD_NS)

// clear pulse window after the load request sets
`define RSL_CLR_MIN_NS      170
`define RSL_CLR_MAX_NS      370

// scan ticks from halt to load strobe, about 2 us at 2.54 MHz
`define RSL_LOAD_TICKS      5

// silo storage
`define RSL_SILO_DEPTH      64
`define RSL_SILO_AW         6

// maintenance test pattern
`define RSL_TEST_PATTERN    16'haaaa

// reset values
`define RSL_ACC_RST         14'h0000
`define RSL_CHAR_RST        16'h0000

`endif

// ---- design/rsl_pkg.sv ----
// types of the receive silo load sequencer
// assumes rsl_defines.svh supplies all numeric constants
package rsl_pkg;

    typedef logic [15:0] rsl_char_t;

    // receiver sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_LOAD
    } rsl_seq_e;

    // silo load-request states
    typedef enum logic [1:0] {
        SL_IDLE,
        SL_DELAY,
        SL_CLR
    } rsl_silo_e;

endpackage

// ---- design/rsl_buf2.sv ----
// two-entry buffer between silo output and the host read port
// assumes in_data is stable while in_valid is high and not yet taken
`timescale 1ns/1ps
`include "rsl_defines.svh"

module rsl_buf2 (
    input  wire logic              mclk,      // system clock
    input  wire logic              resetn,    // async reset, active low
    input  wire logic              in_valid,  // word offered
    output logic                   in_ready,  // room for a word
    input  rsl_pkg::rsl_char_t     in_data,   // offered word
    output logic                   out_valid, // word available
    input  wire logic              out_ready, // word taken
    output rsl_pkg::rsl_char_t     out_data   // head word
);
    import rsl_pkg::*;

    rsl_char_t   mem_r [2];
    logic        wp_r;
    logic        rp_r;
    logic [1:0]  cnt_r;
    logic        push;
    logic        pop;

    // full and empty come straight from the count so back-pressure is honest
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rp_r];

    // storage, written only on push
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mem_r[0] <= `RSL_CHAR_RST;
            mem_r[1] <= `RSL_CHAR_RST;
        end else if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) wp_r <= ~wp_r;
            if (pop) rp_r <= ~rp_r;
            if (push && !pop) cnt_r <= cnt_r + 2'h1;
            else if (pop && !push) cnt_r <= cnt_r - 2'h1;
        end
    end

endmodule // rsl_buf2

// ---- design/receive_silo_load_sequencer.sv ----
// receive silo load sequencer: scan halt, load strobe, load request and silo storage
// assumes scanner inputs and host read strobe are synchronous to mclk
`timescale 1ns/1ps
`include "rsl_defines.svh"

// Overview of operation
// [R01] maintenance control yields one simulated data-available pulse
// [R02] test pattern and pulse formed while maintenance set
// [R03] pulse halts scan; halt drives load strobe
// [R04] sequencer moves only on 2.54 MHz ticks
// [R05] silo logic paced by its 5.068 MHz tick
// [R06] every load strobe sets load pending
// [R07] short clear pulse 170-370 ns after pending
// [R08] each host read removes one character
// [R09] interrupt requests given as rising transitions
// [R10] first in first out; full drops loads
// [R11] load strobe synchronised before updating pending
module receive_silo_load_sequencer (
    input  wire logic           mclk,           // system clock, 10 MHz
    input  wire logic           resetn,         // async reset, active low
    input  wire logic           maint_en,       // silo maintenance control level
    input  wire logic           data_avail,     // scanner found a data-available flag
    input  rsl_pkg::rsl_char_t  rx_char,        // character from the scanned receiver
    input  wire logic           nrc_rd,         // host read of next_received_char_reg, pulse
    output logic                maint_pulse,    // maintenance pulse, active high
    output rsl_pkg::rsl_char_t  test_pattern,   // pattern offered for silo entry
    output logic                scan_halt,      // scanner halted for a load
    output logic                fifo_load_n,    // load strobe, active low
    output logic                load_pending,   // silo load request flag
    output logic                load_clr_n,     // load request clear pulse, active low
    output logic                nrc_valid,      // next_received_char_reg holds a character
    output rsl_pkg::rsl_char_t  nrc_data,       // next_received_char_reg contents
    output logic                char_avail_req, // character-available request level
    output logic                overflow_req    // silo overflow request pulse
);
    import rsl_pkg::*;

    localparam logic [13:0] MCLK_KHZ = 14'(`RSL_MCLK_KHZ);
    localparam logic [3:0]  MP_CYC   = 4'(`RSL_MAINT_PULSE_CYC);
    localparam logic [2:0]  LD_TICKS = 3'(`RSL_LOAD_TICKS);
    localparam logic [1:0]  CLR_CYC  = 2'(`RSL_CLR_PULSE_CYC);
    localparam logic [6:0]  DEPTH    = 7'(`RSL_SILO_DEPTH);

    // tick[0] scanner rate, tick[1] silo rate
    logic [1:0]  tick;

    // fractional accumulators give average rates without a second clock domain
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tick
            localparam logic [13:0] STEP = (g == 0) ? 14'(`RSL_SCAN_KHZ) : 14'(`RSL_SILO_KHZ);
            logic [13:0] acc_r;
            logic [14:0] sum;
            logic        tick_r;
            assign sum     = {1'b0, acc_r} + {1'b0, STEP};
            assign tick[g] = tick_r;
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    acc_r  <= `RSL_ACC_RST;
                    tick_r <= 1'b0;
                end else if (sum >= {1'b0, MCLK_KHZ}) begin
                    acc_r  <= 14'(sum - {1'b0, MCLK_KHZ});
                    tick_r <= 1'b1;
                end else begin
                    acc_r  <= sum[13:0];
                    tick_r <= 1'b0;
                end
            end
        end
    endgenerate

    // maintenance pulse: one per setting of the control, so a level held high runs one load
    logic       maint_d_r;
    logic [3:0] mp_cnt_r;
    logic       mp_start;
    assign mp_start = maint_en & ~maint_d_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            maint_d_r   <= 1'b0;
            mp_cnt_r    <= 4'h0;
            maint_pulse <= 1'b0;
        end else begin
            maint_d_r <= maint_en;
            if (mp_start) begin                       // [R01]
                mp_cnt_r    <= MP_CYC - 4'h1;
                maint_pulse <= 1'b1;                   // [R02]
            end else if (mp_cnt_r != 4'h0) begin
                mp_cnt_r <= mp_cnt_r - 4'h1;
            end else begin
                maint_pulse <= 1'b0;
            end
        end
    end

    // test pattern is presented, one cycle late, for the whole time maintenance is set
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) test_pattern <= `RSL_CHAR_RST;
        else test_pattern <= maint_en ? `RSL_TEST_PATTERN : `RSL_CHAR_RST; // [R02]
    end

    // scan halt and the character it carries; maintenance stands in for data available
    rsl_seq_e  seq_r;
    logic [2:0] seq_cnt_r;
    rsl_char_t  seq_char_r;
    logic       halt_trig;
    logic       seq_done;
    assign halt_trig = (mp_start | data_avail) & ~scan_halt;
    assign seq_done  = (seq_r == SEQ_LOAD) & tick[0];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scan_halt  <= 1'b0;
            seq_char_r <= `RSL_CHAR_RST;
        end else if (halt_trig) begin
            scan_halt  <= 1'b1;                                      // [R03]
            seq_char_r <= mp_start ? `RSL_TEST_PATTERN : rx_char;    // [R01]
        end else if (seq_done) begin
            scan_halt <= 1'b0;
        end
    end

    // receiver sequencer: waits for scan ticks, then strobes the load for one tick period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seq_r       <= SEQ_IDLE;
            seq_cnt_r   <= 3'h0;
            fifo_load_n <= 1'b1;
        end else begin
            case (seq_r)
                SEQ_IDLE: begin
                    if (scan_halt && tick[0]) begin                  // [R04]
                        seq_r     <= SEQ_WAIT;
                        seq_cnt_r <= 3'h1;
                    end
                end
                SEQ_WAIT: begin
                    if (tick[0]) begin                               // [R04]
                        if (seq_cnt_r == LD_TICKS - 3'h1) begin
                            seq_r       <= SEQ_LOAD;
                            fifo_load_n <= 1'b0;                     // [R03]
                        end else begin
                            seq_cnt_r <= seq_cnt_r + 3'h1;
                        end
                    end
                end
                SEQ_LOAD: begin
                    if (tick[0]) begin
                        seq_r       <= SEQ_IDLE;
                        fifo_load_n <= 1'b1;
                    end
                end
                default: begin
                    seq_r       <= SEQ_IDLE;
                    fifo_load_n <= 1'b1;
                end
            endcase
        end
    end

    // strobe synchroniser into the silo logic; the first stage feeds only the second
    logic ld_s1_r;
    logic ld_s2_r;
    logic ld_s3_r;
    logic ld_fall;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ld_s1_r <= 1'b1;
            ld_s2_r <= 1'b1;
            ld_s3_r <= 1'b1;
        end else begin
            ld_s1_r <= fifo_load_n;                                  // [R11]
            ld_s2_r <= ld_s1_r;
            ld_s3_r <= ld_s2_r;
        end
    end
    assign ld_fall = ~ld_s2_r & ld_s3_r;

    // load request flag; a new strobe in the clearing cycle wins so no load is lost
    rsl_char_t din_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_pending <= 1'b0;
            din_r        <= `RSL_CHAR_RST;
        end else begin
            if (ld_fall) begin
                load_pending <= 1'b1;                                // [R06]
                din_r        <= seq_char_r;
            end else if (!load_clr_n) begin
                load_pending <= 1'b0;                                // [R07]
            end
        end
    end

    // silo control: clear pulse lands on the next silo tick, 200 to 300 ns after pending
    rsl_silo_e sl_r;
    logic [1:0] clr_cnt_r;
    logic       sl_write;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sl_r       <= SL_IDLE;
            clr_cnt_r  <= 2'h0;
            load_clr_n <= 1'b1;
        end else begin
            case (sl_r)
                SL_IDLE: begin
                    if (load_pending) sl_r <= SL_DELAY;
                end
                SL_DELAY: begin
                    if (tick[1]) begin                               // [R05]
                        sl_r       <= SL_CLR;
                        clr_cnt_r  <= CLR_CYC - 2'h1;
                        load_clr_n <= 1'b0;                          // [R07]
                    end
                end
                SL_CLR: begin
                    if (clr_cnt_r != 2'h0) begin
                        clr_cnt_r <= clr_cnt_r - 2'h1;
                    end else begin
                        sl_r       <= SL_IDLE;
                        load_clr_n <= 1'b1;
                    end
                end
                default: begin
                    sl_r       <= SL_IDLE;
                    load_clr_n <= 1'b1;
                end
            endcase
        end
    end
    // entry is written as the clear pulse begins
    assign sl_write = (sl_r == SL_DELAY) & tick[1];

    // silo storage; a load into a full silo is dropped and flagged
    rsl_char_t                silo_mem [`RSL_SILO_DEPTH];
    logic [`RSL_SILO_AW-1:0]  wr_ptr_r;
    logic [`RSL_SILO_AW-1:0]  rd_ptr_r;
    logic [6:0]               cnt_r;
    logic                     do_wr;
    logic                     do_rd;
    logic                     buf_ready;
    logic                     buf_valid;
    assign do_wr = sl_write & (cnt_r != DEPTH);                      // [R10]
    assign do_rd = (cnt_r != 7'h00) & buf_ready;

    always_ff @(posedge mclk) begin
        if (do_wr) silo_mem[wr_ptr_r] <= din_r;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= 7'h00;
        end else begin
            if (do_wr) wr_ptr_r <= wr_ptr_r + 6'h01;
            if (do_rd) rd_ptr_r <= rd_ptr_r + 6'h01;                 // [R10]
            if (do_wr && !do_rd) cnt_r <= cnt_r + 7'h01;
            else if (do_rd && !do_wr) cnt_r <= cnt_r - 7'h01;
        end
    end

    // output stage; a read when nothing is held is ignored
    rsl_buf2 u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (cnt_r != 7'h00),
        .in_ready  (buf_ready),
        .in_data   (silo_mem[rd_ptr_r]),
        .out_valid (buf_valid),
        .out_ready (nrc_rd),                                         // [R08]
        .out_data  (nrc_data)
    );
    assign nrc_valid = buf_valid;

    // request lines: each read drops the level a cycle so a further character rises again
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            char_avail_req <= 1'b0;
            overflow_req   <= 1'b0;
        end else begin
            char_avail_req <= buf_valid & ~nrc_rd;                   // [R09]
            overflow_req   <= sl_write & (cnt_r == DEPTH);           // [R09]
        end
    end

    // pulse length for the width check; a long repetition would be slow to unroll, so count instead
    logic [3:0] mp_len_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) mp_len_r <= 4'h0;
        else if (!maint_pulse) mp_len_r <= 4'h0;
        else if (mp_len_r != 4'hf) mp_len_r <= mp_len_r + 4'h1;
    end

    // checks
    AST_MAINT_WIDTH: assert property (@(posedge mclk) disable iff (!resetn) // [R01]
        $fell(maint_pulse) |-> mp_len_r == MP_CYC)
        else $error("maintenance pulse width wrong");
    AST_PATTERN: assert property (@(posedge mclk) disable iff (!resetn) // [R02]
        (maint_en && $past(maint_en)) |-> test_pattern == `RSL_TEST_PATTERN)
        else $error("test pattern missing while maintenance set");
    AST_HALT_ON_PULSE: assert property (@(posedge mclk) disable iff (!resetn) // [R03]
        $rose(maint_pulse) |=> scan_halt)
        else $error("maintenance pulse did not halt scan");
    AST_LOAD_HALTED: assert property (@(posedge mclk) disable iff (!resetn) // [R03]
        $fell(fifo_load_n) |-> scan_halt)
        else $error("load strobe without scan halt");
    AST_LOAD_ON_TICK: assert property (@(posedge mclk) disable iff (!resetn) // [R04]
        $fell(fifo_load_n) |-> $past(tick[0]))
        else $error("load strobe not on scan tick");
    AST_CLR_ON_TICK: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
        $fell(load_clr_n) |-> $past(tick[1]))
        else $error("clear pulse not on silo tick");
    AST_PEND_SET: assert property (@(posedge mclk) disable iff (!resetn) // [R06]
        (!ld_s2_r && ld_s3_r) |=> load_pending)
        else $error("synchronised strobe did not set pending");
    AST_CLR_WINDOW: assert property (@(posedge mclk) disable iff (!resetn) // [R07]
        $rose(load_pending) |-> ##[2:3] (!load_clr_n ##1 (load_clr_n && !load_pending)))
        else $error("clear pulse outside window");
    AST_OVF_FULL: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
        overflow_req |-> $past(cnt_r) == DEPTH)
        else $error("overflow flagged without full silo");
    AST_REQ_EDGE: assert property (@(posedge mclk) disable iff (!resetn) // [R09]
        overflow_req |=> !overflow_req)
        else $error("overflow request held high");
    AST_READ_DROP: assert property (@(posedge mclk) disable iff (!resetn) // [R08]
        (nrc_rd && nrc_valid) |=> !char_avail_req)
        else $error("read did not drop character request");

endmodule // receive_silo_load_sequencer

// ---- tb/rsl_scan_model.sv ----
// far-side model: receiver scanner offering characters, host reading the next-character port
// assumes one mclk; the bench calls send() and sets rd_en, rd_gap and rd_stray
`timescale 1ns/1ps

module rsl_scan_model (
    input  wire logic          mclk,       // system clock
    input  wire logic          resetn,     // async reset, active low
    input  wire logic          scan_halt,  // scanner halted by the block
    input  wire logic          nrc_valid,  // a character waits
    input  rsl_pkg::rsl_char_t nrc_data,   // waiting character
    output logic               data_avail, // found data, one-cycle pulse
    output rsl_pkg::rsl_char_t rx_char,    // character offered with it
    output logic               nrc_rd      // host read pulse
);
    import rsl_pkg::*;
    logic      rd_en;    // host reads whenever a character waits
    logic      rd_stray; // one read whatever nrc_valid says
    int        rd_gap;   // idle cycles after each read, a slow host
    int        gap_cnt;  // idle cycles left
    rsl_char_t got_q[$]; // characters taken by the host

    // quiet start
    initial begin
        data_avail = 1'b0;
        rx_char    = 16'h0000;
        nrc_rd     = 1'b0;
        rd_en      = 1'b0;
        rd_stray   = 1'b0;
        rd_gap     = 0;
        gap_cnt    = 0;
    end

    // offer one character once the scanner runs; the data lines are scrambled afterwards
    task automatic send(input rsl_char_t c);
        int n;
        n = 0;
        @(posedge mclk);
        while (scan_halt !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        data_avail <= 1'b1;
        rx_char    <= c;
        @(posedge mclk);
        data_avail <= 1'b0;
        rx_char    <= ~c; // no stale value left standing
    endtask

    // host: the word is taken at the edge that sees the read, then the gap runs out
    always @(posedge mclk) begin
        if (nrc_rd && nrc_valid)
            got_q.push_back(nrc_data);
        if (!resetn || nrc_rd) begin
            nrc_rd  <= 1'b0;
            gap_cnt <= rd_gap;
        end else if (gap_cnt > 0)
            gap_cnt <= gap_cnt - 1;
        else if ((rd_en && nrc_valid) || rd_stray)
            nrc_rd <= 1'b1;
    end
endmodule // rsl_scan_model

// ---- tb/receive_silo_load_sequencer_bench.sv ----
// self-checking bench: queue model of the silo compared with every character read out
// assumes the far side is rsl_scan_model; maintenance and reset are driven here
`timescale 1ns/1ps

module receive_silo_load_sequencer_bench;
    import rsl_pkg::*;
    logic      mclk, resetn, maint_en, data_avail, nrc_rd, maint_pulse, scan_halt;
    logic      fifo_load_n, load_pending, load_clr_n, nrc_valid, char_avail_req, overflow_req;
    rsl_char_t rx_char, test_pattern, nrc_data, c;
    int        error_cnt, compares, cyc, ovf_cnt, ovf_exp, ld_age, pd_age, k;
    logic      fl_q, lp_q, cl_q;
    rsl_char_t exp_q[$]; // characters the silo must return, oldest first

    receive_silo_load_sequencer i_dut (.mclk(mclk), .resetn(resetn), .maint_en(maint_en),
        .data_avail(data_avail), .rx_char(rx_char), .nrc_rd(nrc_rd), .maint_pulse(maint_pulse),
        .test_pattern(test_pattern), .scan_halt(scan_halt), .fifo_load_n(fifo_load_n),
        .load_pending(load_pending), .load_clr_n(load_clr_n), .nrc_valid(nrc_valid),
        .nrc_data(nrc_data), .char_avail_req(char_avail_req), .overflow_req(overflow_req));

    rsl_scan_model i_model (.mclk(mclk), .resetn(resetn), .scan_halt(scan_halt),
        .nrc_valid(nrc_valid), .nrc_data(nrc_data), .data_avail(data_avail),
        .rx_char(rx_char), .nrc_rd(nrc_rd));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // wait, bounded, until every expected character has reached the host
    task automatic drain_cmp();
        int n;
        n = 0;
        while (i_model.got_q.size() < exp_q.size() && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        check(i_model.got_q.size(), exp_q.size());
        foreach (exp_q[i])
            if (i < i_model.got_q.size())
                check(i_model.got_q[i], exp_q[i]);
        exp_q.delete();
        i_model.got_q.delete();
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // per-load timing and overflow pulses over the whole run; cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc++;
        if (resetn) begin
            ld_age++;
            pd_age++;
            if (fl_q && !fifo_load_n)
                ld_age = 0;
            if (!lp_q && load_pending) begin
                check(ld_age, 3);
                pd_age = 0;
            end
            if (cl_q && !load_clr_n)
                check(pd_age == 2 || pd_age == 3, 1);
            if (overflow_req === 1'b1)
                ovf_cnt++;
        end
        fl_q = fifo_load_n;
        lp_q = load_pending;
        cl_q = load_clr_n;
        if (cyc > 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        {error_cnt, compares, cyc, ovf_cnt, ovf_exp, ld_age, pd_age} = '0;
        {fl_q, lp_q, cl_q} = 3'b101;
        resetn   = 1'b0;
        maint_en = 1'b0;
        void'($urandom(32'h4dbaedcc));
        repeat (6) @(posedge mclk);
        check({fifo_load_n, load_clr_n, scan_halt, load_pending, nrc_valid}, 5'h18);
        check({char_avail_req, overflow_req, maint_pulse}, 3'h0);
        resetn <= 1'b1;
        $display("test reset done");

        // maintenance: pattern, pulse, halt, strobe some 2 us later, pattern lands in the silo
        repeat (2) @(posedge mclk);
        maint_en <= 1'b1;
        exp_q.push_back(16'haaaa);
        repeat (2) @(posedge mclk);
        check(test_pattern, 16'haaaa);
        check({maint_pulse, scan_halt}, 2'b11);
        k = 0;
        while (fifo_load_n !== 1'b0 && k < 40) begin
            @(posedge mclk);
            k++;
        end
        check(k >= 9 && k <= 22, 1);
        check(scan_halt, 1'b1);
        while (nrc_valid !== 1'b1 && k < 200) begin
            @(posedge mclk);
            k++;
        end
        repeat (2) @(posedge mclk);
        check({char_avail_req, nrc_data}, {1'b1, 16'haaaa});
        maint_en <= 1'b0;
        repeat (2) @(posedge mclk);
        check({test_pattern, maint_pulse}, 17'h0);
        i_model.rd_en <= 1'b1;
        drain_cmp();
        repeat (2) @(posedge mclk);
        check({char_avail_req, nrc_valid}, 2'b00);
        $display("test maintenance done");

        // read of an empty port is ignored
        i_model.rd_en    <= 1'b0;
        i_model.rd_stray <= 1'b1;
        @(posedge mclk);
        i_model.rd_stray <= 1'b0;
        repeat (3) @(posedge mclk);
        check({nrc_valid, char_avail_req, i_model.got_q.size() == 0}, 3'b001);
        $display("test empty read done");

        // random stream with a host of random speed
        i_model.rd_en <= 1'b1;
        for (k = 0; k < 24; k++) begin
            c = 16'($urandom());
            i_model.rd_gap <= $urandom_range(5, 0);
            exp_q.push_back(c);
            i_model.send(c);
        end
        drain_cmp();
        $display("test stream done");

        // stalled host: fill 64 silo plus 2 buffer entries, two more loads are dropped
        i_model.rd_en  <= 1'b0;
        i_model.rd_gap <= 0;
        for (k = 0; k < 68; k++) begin
            c = 16'($urandom());
            if (k < 66)
                exp_q.push_back(c);
            else
                ovf_exp++;
            i_model.send(c);
        end
        k = 0;
        while (ovf_cnt < ovf_exp && k < 200) begin
            @(posedge mclk);
            k++;
        end
        repeat (2) @(posedge mclk);
        check(ovf_cnt, 2);
        check({char_avail_req, nrc_data}, {1'b1, exp_q[0]});
        i_model.rd_en <= 1'b1;
        drain_cmp();
        repeat (3) @(posedge mclk);
        check({nrc_valid, char_avail_req}, 2'b00);
        check(ovf_cnt, ovf_exp);
        $display("test fill done");
        give_verdict();
    end
endmodule // receive_silo_load_sequencer_bench
